/* File: verification/mdc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mdc_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] frame_rdata,
	output var  logic        frame_valid,
	output var  logic        frame_crc_ok,
	output var  logic        frame_write,
	output var  logic [6:0]  frame_addr,
	output var  logic [15:0] frame_wdata
);
	initial begin
		frame_valid = 1'b0;
		frame_crc_ok = 1'b0;
		frame_write = 1'b0;
		frame_addr = 7'h00;
		frame_wdata = 16'h0000;
	end

	// One whole 16-bit register per frame; entered just after a rising edge.
	task automatic xfer(input logic w, input logic ok, input logic [6:0] a,
		input logic [15:0] d, output logic [15:0] rd);
		frame_valid = 1'b1;
		frame_write = w;
		frame_crc_ok = ok;
		frame_addr = a;
		frame_wdata = d;
		@(posedge clk);
		#1;
		rd = frame_rdata;
		// Released lines show the inverse so stale values never pass.
		frame_valid = 1'b0;
		frame_write = ~w;
		frame_crc_ok = ~ok;
		frame_addr = ~a;
		frame_wdata = ~d;
		@(posedge clk);
		#1;
	endtask : xfer
endmodule : mdc_host_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [6:0] A_IRQ = mdc_pkg::IRQ_MASK_CONTROL_ADDR;
	localparam logic [6:0] A_SCR = mdc_pkg::SYSTEM_SCRATCH_STORE_ADDR;
	localparam logic [6:0] A_GEN = mdc_pkg::BRIDGE_GENERAL_CONTROL_ADDR;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        restart = 1'b0;
	logic        normal_mode = 1'b1;
	logic [4:0]  ev = 5'h00;
	logic [15:0] rd;
	wire logic   fv, fok, fw;
	wire logic [6:0]  fa;
	wire logic [15:0] fwd, frd;
	wire logic   irq;
	wire logic [1:0]  mk;
	wire logic [5:0]  br;
	wire logic [7:0]  lo;
	int          error_cnt = 0;
	int          samples_checked = 0;

	always #25 clk = ~clk;

	mdc_host_model host (.clk(clk), .frame_rdata(frd), .frame_valid(fv),
		.frame_crc_ok(fok), .frame_write(fw), .frame_addr(fa), .frame_wdata(fwd));

	mdc_ctrl_regs dut (.clk(clk), .rst(rst), .restart(restart),
		.normal_mode(normal_mode), .frame_valid(fv), .frame_crc_ok(fok),
		.frame_write(fw), .frame_addr(fa), .frame_wdata(fwd), .frame_rdata(frd),
		.supply_stat_set(ev[0]), .temp_stat_set(ev[1]), .bridge_stat_set(ev[2]),
		.spi_crc_fail_set(ev[3]), .wd_dev_fail_set(ev[4]), .irq_out_low(irq),
		.irq_cyclic_en(mk[1]), .wd_dev_disable(mk[0]),
		.bridge_sync_freq_sel(br[5]), .pump_undervolt_thresh_sel(br[4]),
		.gate_level_sel(br[3]), .pump_stage_auto_switch(br[2]),
		.overvolt_recover_en(br[1]), .precharge_adapt_step(br[0]),
		.bridge_ctrl_low(lo));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		host.xfer(1'b1, 1'b1, a, d, rd);
	endtask : wr

	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		host.xfer(1'b0, 1'b1, a, 16'h0000, rd);
		chk(rd, exp);
	endtask : rdc

	// Pulses one flag and checks how many cycles the interrupt line stayed low against exp.
	task automatic irq_len(input int b, input int exp);
		int n;
		n = 0;
		ev[b] = 1'b1;
		cyc(1);
		ev[b] = 1'b0;
		while (irq === 1'b0 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(16'(n), 16'(exp));
		if (n >= 40) end_sim;
	endtask : irq_len

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	initial begin
		#1000000;
		error_cnt++;
		end_sim;
	end

	initial begin
		cyc(20);
		rst = 1'b0;
		chk({mk, br, lo}, 16'h8801);
		rdc(A_IRQ, 16'h0140);
		rdc(A_SCR, 16'h0000);
		rdc(A_GEN, 16'h0801);
		rdc(7'h7f, 16'h0000);
		wr(A_GEN, 16'hffff);
		chk({mk, br, lo}, 16'hbfff);
		rdc(A_GEN, 16'h9fff);
		wr(A_IRQ, 16'hffff);
		chk({mk, br, lo}, 16'hffff);
		rdc(A_IRQ, 16'h01ff);
		wr(A_SCR, 16'ha5c3);
		restart = 1'b1;
		cyc(1);
		restart = 1'b0;
		rdc(A_IRQ, 16'h01ff);
		rdc(A_SCR, 16'ha5c3);
		host.xfer(1'b1, 1'b0, A_SCR, 16'h0000, rd);
		chk(rd, 16'ha5c3);
		rdc(A_SCR, 16'ha5c3);
		normal_mode = 1'b0;
		wr(A_SCR, 16'h1111);
		rdc(A_SCR, 16'h0000);
		normal_mode = 1'b1;
		rdc(A_SCR, 16'ha5c3);
		wr(A_IRQ, 16'h0003);
		irq_len(1, 20);
		irq_len(0, 20);
		ev[1] = 1'b1;
		cyc(1);
		ev[1] = 1'b0;
		cyc(5);
		irq_len(1, 20);
		wr(A_IRQ, 16'h0070);
		for (int b = 2; b < 5; b++) irq_len(b, 20);
		irq_len(1, 0);
		irq_len(0, 0);
		// A reset on rst in mid-run must bring every field back, the scratch store included.
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		chk({mk, br, lo}, 16'h8801);
		rdc(A_SCR, 16'h0000);
		rdc(A_IRQ, 16'h0140);
		end_sim;
	end
endmodule : testbench
`default_nettype wire

/* File: verilog/mdc_ctrl_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module mdc_ctrl_regs (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        restart,
	input  wire logic        normal_mode,
	input  wire logic        frame_valid,
	input  wire logic        frame_crc_ok,
	input  wire logic        frame_write,
	input  wire logic [6:0]  frame_addr,
	input  wire logic [15:0] frame_wdata,
	output var  logic [15:0] frame_rdata,
	input  wire logic        supply_stat_set,
	input  wire logic        temp_stat_set,
	input  wire logic        bridge_stat_set,
	input  wire logic        spi_crc_fail_set,
	input  wire logic        wd_dev_fail_set,
	output var  logic        irq_out_low,
	output var  logic        irq_cyclic_en,
	output var  logic        wd_dev_disable,
	output var  logic        bridge_sync_freq_sel,
	output var  logic        pump_undervolt_thresh_sel,
	output var  logic        gate_level_sel,
	output var  logic        pump_stage_auto_switch,
	output var  logic        overvolt_recover_en,
	output var  logic        precharge_adapt_step,
	output var  logic [7:0]  bridge_ctrl_low
);
	logic [15:0] mask_q;
	logic [15:0] mask_d;
	logic [15:0] scratch_q;
	logic [15:0] scratch_d;
	logic [15:0] gen_q;
	logic [15:0] gen_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	wire frame_ok    = frame_valid && frame_crc_ok;
	wire wr_ok       = frame_ok && frame_write;
	wire hit_mask    = frame_addr == mdc_pkg::IRQ_MASK_CONTROL_ADDR;
	wire hit_scratch = frame_addr == mdc_pkg::SYSTEM_SCRATCH_STORE_ADDR;
	wire hit_gen     = frame_addr == mdc_pkg::BRIDGE_GENERAL_CONTROL_ADDR;
	wire wr_mask     = wr_ok && hit_mask;
	// Outside normal mode the scratch store is sealed both ways.
	wire wr_scratch  = wr_ok && hit_scratch && normal_mode;
	wire wr_gen      = wr_ok && hit_gen;

	// Bits 15 to 9 of the mask never hold a one.
	assign mask_d = wr_mask ? (frame_wdata & mdc_pkg::IRQ_MASK_RESTART_KEEP) :
		restart ? (mask_q & mdc_pkg::IRQ_MASK_RESTART_KEEP) : mask_q;

	// Restart and fail-safe are deliberately not inputs of this path.
	assign scratch_d = wr_scratch ? frame_wdata : scratch_q;

	// Reserved bits are stripped at the write, so they read back as zero.
	assign gen_d = wr_gen ? (frame_wdata & mdc_pkg::GEN_WRITE_MASK) : gen_q;

	assign rdata_d = !frame_ok ? rdata_q :
		hit_mask ? mask_q :
		(hit_scratch && normal_mode) ? scratch_q :
		hit_gen ? gen_q : 16'h0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q    <= mdc_pkg::IRQ_MASK_RESET;
			scratch_q <= mdc_pkg::SCRATCH_RESET;
			gen_q     <= mdc_pkg::GEN_RESET;
			rdata_q   <= 16'h0000;
		end else begin
			mask_q    <= mask_d;
			scratch_q <= scratch_d;
			gen_q     <= gen_d;
			rdata_q   <= rdata_d;
		end
	end

	assign frame_rdata = rdata_q;

	// The status flags are set pulses; whether the flag was already set does not matter.
	wire irq_event =
		(temp_stat_set    && mask_q[mdc_pkg::MASK_TEMP_BIT])   ||
		(supply_stat_set  && mask_q[mdc_pkg::MASK_SUPPLY_BIT]) ||
		(bridge_stat_set  && mask_q[mdc_pkg::MASK_BRIDGE_BIT]) ||
		(spi_crc_fail_set && mask_q[mdc_pkg::MASK_SPI_CRC_BIT]) ||
		(wd_dev_fail_set  && mask_q[mdc_pkg::MASK_WD_DEV_BIT]);

	mdc_irq_pulse u_irq_pulse (
		.clk         (clk),
		.rst         (rst),
		.event_in    (irq_event),
		.irq_out_low (irq_out_low)
	);

	assign irq_cyclic_en             = mask_q[mdc_pkg::MASK_CYCLIC_BIT];
	assign wd_dev_disable            = mask_q[mdc_pkg::MASK_WD_DEV_DIS_BIT];
	assign bridge_sync_freq_sel      = gen_q[mdc_pkg::GEN_FREQ_BIT];
	assign pump_undervolt_thresh_sel = gen_q[mdc_pkg::GEN_THRESH_BIT];
	assign gate_level_sel            = gen_q[mdc_pkg::GEN_GATE_BIT];
	assign pump_stage_auto_switch    = gen_q[mdc_pkg::GEN_STAGE_BIT];
	assign overvolt_recover_en       = gen_q[mdc_pkg::GEN_RECOVER_BIT];
	assign precharge_adapt_step      = gen_q[mdc_pkg::GEN_ADAPT_BIT];
	assign bridge_ctrl_low           = gen_q[7:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire others_quiet = !bridge_stat_set && !spi_crc_fail_set && !wd_dev_fail_set;

	property p_temp_irq;
		temp_stat_set && mask_q[1] |=> !irq_out_low;
	endproperty
	a_temp_irq: assert property (p_temp_irq) else $error("thermal event gave no interrupt");

	property p_temp_quiet;
		temp_stat_set && !mask_q[1] && !supply_stat_set && others_quiet && irq_out_low
			|=> irq_out_low;
	endproperty
	a_temp_quiet: assert property (p_temp_quiet) else $error("masked thermal event fired");

	property p_supply_irq;
		supply_stat_set && mask_q[0] |=> !irq_out_low;
	endproperty
	a_supply_irq: assert property (p_supply_irq) else $error("supply event gave no interrupt");

	property p_supply_quiet;
		supply_stat_set && !mask_q[0] && !temp_stat_set && others_quiet && irq_out_low
			|=> irq_out_low;
	endproperty
	a_supply_quiet: assert property (p_supply_quiet) else $error("masked supply event fired");

	// Checked at the first edge after release, so the unknown history before time zero never counts.
	property p_reset_values;
		$past(rst) && !rst |-> mask_q == mdc_pkg::IRQ_MASK_RESET
			&& scratch_q == mdc_pkg::SCRATCH_RESET && gen_q == mdc_pkg::GEN_RESET
			&& irq_out_low && frame_rdata == 16'h0000;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("wrong value after reset");

	property p_restart_keep;
		restart && !wr_ok |=> mask_q == $past(mask_q) && mask_q[15:9] == 7'h00;
	endproperty
	a_restart_keep: assert property (p_restart_keep) else $error("restart changed mask");

	property p_scratch_hold;
		!(wr_ok && hit_scratch && normal_mode) |=> $stable(scratch_q);
	endproperty
	a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed unbidden");

	property p_scratch_write;
		wr_ok && hit_scratch && normal_mode |=> scratch_q == $past(frame_wdata);
	endproperty
	a_scratch_write: assert property (p_scratch_write) else $error("scratch write lost");

	property p_scratch_sealed;
		frame_ok && hit_scratch && !normal_mode |=> frame_rdata == 16'h0000;
	endproperty
	a_scratch_sealed: assert property (p_scratch_sealed) else $error("scratch read outside normal");

	property p_res_zero;
		frame_ok && hit_gen |=> frame_rdata[14:13] == 2'b00;
	endproperty
	a_res_zero: assert property (p_res_zero) else $error("reserved bits read nonzero");

	property p_gen_write;
		wr_gen |=> bridge_sync_freq_sel == $past(frame_wdata[15])
			&& pump_undervolt_thresh_sel == $past(frame_wdata[12]);
	endproperty
	a_gen_write: assert property (p_gen_write) else $error("control write lost");

	property p_bad_frame;
		frame_valid && !frame_crc_ok && !restart |=> $stable(mask_q) && $stable(gen_q)
			&& $stable(scratch_q) && $stable(frame_rdata);
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame changed a register");

	c_temp_irq:   cover property (temp_stat_set && mask_q[1] ##1 !irq_out_low);
	c_scratch_wr: cover property (wr_scratch ##2 frame_ok && hit_scratch);
	c_gen_wr:     cover property (wr_gen);
	c_bad_frame:  cover property (frame_valid && !frame_crc_ok && frame_write);
endmodule : mdc_ctrl_regs
`default_nettype wire

/* File: verilog/mdc_irq_pulse.sv */
`timescale 1ns/1ns
`default_nettype none
module mdc_irq_pulse (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic event_in,
	output var  logic irq_out_low
);
	logic [mdc_pkg::IRQ_CNT_W-1:0] cnt_q;
	logic [mdc_pkg::IRQ_CNT_W-1:0] cnt_d;
	logic                          irq_low_q;

	// A new event restarts the pulse, so back-to-back events are never merged into nothing.
	assign cnt_d = event_in ? mdc_pkg::IRQ_PULSE_LOAD :
		(cnt_q != '0) ? cnt_q - 5'h01 : cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q     <= '0;
			irq_low_q <= 1'b1;
		end else begin
			cnt_q     <= cnt_d;
			irq_low_q <= (cnt_d == '0);
		end
	end

	assign irq_out_low = irq_low_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_pulse_width;
		$fell(irq_out_low) |-> !irq_out_low [*8];
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("interrupt pulse too short");
endmodule : mdc_irq_pulse
`default_nettype wire

/* File: verilog/mdc_pkg.sv */
package mdc_pkg;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 16;

	// Register offsets as used in the frame address field.
	localparam logic [6:0] IRQ_MASK_CONTROL_ADDR      = 7'h09;
	localparam logic [6:0] SYSTEM_SCRATCH_STORE_ADDR  = 7'h0b;
	localparam logic [6:0] BRIDGE_GENERAL_CONTROL_ADDR = 7'h10;

	// Interrupt mask layout and reset values.
	localparam int unsigned MASK_W                 = 9;
	localparam int unsigned MASK_SUPPLY_BIT        = 0;
	localparam int unsigned MASK_TEMP_BIT          = 1;
	localparam int unsigned MASK_BRIDGE_BIT        = 4;
	localparam int unsigned MASK_SPI_CRC_BIT       = 5;
	localparam int unsigned MASK_WD_DEV_BIT        = 6;
	localparam int unsigned MASK_WD_DEV_DIS_BIT    = 7;
	localparam int unsigned MASK_CYCLIC_BIT        = 8;
	localparam logic [15:0] IRQ_MASK_RESET         = 16'h0140;
	localparam logic [15:0] IRQ_MASK_RESTART_KEEP  = 16'h01ff;

	// Scratch register reset value.
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;

	// Bridge general control layout and reset values.
	localparam int unsigned GEN_FREQ_BIT     = 15;
	localparam int unsigned GEN_RES_HI_BIT   = 14;
	localparam int unsigned GEN_RES_LO_BIT   = 13;
	localparam int unsigned GEN_THRESH_BIT   = 12;
	localparam int unsigned GEN_GATE_BIT     = 11;
	localparam int unsigned GEN_STAGE_BIT    = 10;
	localparam int unsigned GEN_RECOVER_BIT  = 9;
	localparam int unsigned GEN_ADAPT_BIT    = 8;
	localparam logic [15:0] GEN_RESET        = 16'h0801;
	localparam logic [15:0] GEN_WRITE_MASK   = 16'h9fff;

	// Interrupt pulse timing at a 20 MHz clock.
	localparam int unsigned CLK_PERIOD_NS    = 50;
	localparam int unsigned IRQ_PULSE_NS     = 1000;
	localparam int unsigned IRQ_PULSE_CYCLES =
		(IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IRQ_CNT_W        = 5;
	localparam logic [4:0]  IRQ_PULSE_LOAD   = 5'(IRQ_PULSE_CYCLES);
endpackage : mdc_pkg
